// ===== hdl/ctu_cfg.svh
/*
  Constants of the trap unit: cause bit positions, structure word offsets,
  structure base addresses and trap group codes.
  Assumes it is included by its bare name, once per compilation unit.
*/
`ifndef CTU_CFG_SVH
`define CTU_CFG_SVH

// Cause bit positions in the status and enables words.
`define CTU_BIT_BREAK 4'h0
`define CTU_BIT_INT_ERROR 4'h1
`define CTU_BIT_OVERFLOW 4'h2
`define CTU_BIT_BAD_INSTR 4'h3
`define CTU_BIT_LOAD_ICPT 4'h4
`define CTU_BIT_STORE_ICPT 4'h5
`define CTU_BIT_PRIO_SWITCH 4'hc
`define CTU_BIT_CAUSE_ERR 4'hf

// Trap group codes.
`define CTU_GRP_BREAK 2'h0
`define CTU_GRP_ERRORS 2'h1
`define CTU_GRP_SYSOPS 2'h2
`define CTU_GRP_SCHED 2'h3

// Word offsets inside both structures.
`define CTU_W_ENABLES 2'h0
`define CTU_W_STATUS 2'h1
`define CTU_W_WPTR 2'h2
`define CTU_W_IPTR 2'h3

// Byte base addresses of the structure tables in workspace memory.
`define CTU_HANDLER_BASE 32'h0000_0100
`define CTU_TRAPPED_BASE 32'h0000_0180

// Reset values of the per-priority registers.
`define CTU_EN_RESET 32'h0000_0000
`define CTU_ST_RESET 16'h0000

`endif

// ===== hdl/ctu_pkg.sv
/*
  Types of the trap unit: machine states, instruction codes, bundles.
  Assumes ctu_cfg.svh is not needed here; it holds only types.
*/
package ctu_pkg;

  // Sequencer states.
  typedef enum logic [2:0] {
    CTU_IDLE, CTU_SAVE, CTU_LOAD, CTU_RESTORE, CTU_COPY
  } ctu_fsm_t;

  // Trap instructions handed over by the pipeline.
  typedef enum logic [2:0] {
    CTU_OP_TRAPENB, CTU_OP_TRAPDIS, CTU_OP_TRET, CTU_OP_CAUSEERR,
    CTU_OP_LDTRAPH, CTU_OP_STTRAPH, CTU_OP_LDTRAPPED, CTU_OP_STTRAPPED
  } ctu_op_t;

  // Instruction request: code plus the three stack operands.
  typedef struct packed {
    ctu_op_t code;
    logic [31:0] a;
    logic [31:0] b;
    logic [31:0] c;
  } ctu_req_t;

  // Memory request towards workspace memory.
  typedef struct packed {
    logic req;
    logic we;
    logic [31:0] addr;
    logic [31:0] wdata;
  } ctu_mem_t;

  // Context handed back to the pipeline.
  typedef struct packed {
    logic load;
    logic [31:0] iptr;
    logic [31:0] wptr;
    logic [15:0] status;
  } ctu_ctx_t;

  // Whole state of the trap unit.
  typedef struct packed {
    ctu_fsm_t fsm;
    logic [1:0] idx;
    logic rd_done;
    logic [1:0][31:0] en;
    logic [1:0][15:0] st;
    logic prev_prio;
    logic [1:0][3:0] act_bit;
    logic [1:0][1:0] act_grp;
    logic tprio;
    logic [1:0] tgrp;
    ctu_op_t cop;
    logic [31:0] area;
    logic [31:0] hold_w;
    logic [31:0] hold_i;
    ctu_mem_t mem;
    ctu_ctx_t ctx;
    logic op_done;
    logic [31:0] op_result;
  } ctu_state_t;

endpackage : ctu_pkg

// ===== hdl/cpu_trap_unit.sv
/*
  Trap unit of the processor core: cause detection, per-priority enables
  and status, handler entry, trap return and structure transfers.
  Assumes the pipeline, scheduler and workspace memory share sys_clk_in.
*/
// Summary of operation
// RULE1 - Breakpoint instruction raises bit 0, group 0.
// RULE2 - Other integer errors raise bit 1, group 1.
// RULE3 - Overflow or divide by zero raise bit 2.
// RULE4 - Invalid operate operand raises bit 3, group 2.
// RULE5 - Intercepted structure loads raise bit 4.
// RULE6 - Intercepted structure stores raise bit 5.
// RULE7 - Scheduler events set bits 6 to 11.
// RULE8 - New priority level raises bit 12.
// RULE9 - Idle priority level raises bit 13.
// RULE10 - Cause error sets status bit 15 only; the code also sets the enabled flags given in the operand.
// RULE11 - Handler structure: enables, status, wptr, iptr.
// RULE12 - Handler enables word ANDed into current masks.
// RULE13 - Saved iptr is the following instruction.
// RULE14 - Saved status carries the taken trap bit.
// RULE15 - Separate enables and status per priority.
// RULE16 - Trap taken at interruptible point when enabled.
// RULE17 - Disabled conditions are ignored entirely.
// RULE18 - Enabled conditions set their status bit.
// RULE19 - Entry saves iptr, wptr, status, enables.
// RULE20 - Entry loads handler context, ANDs enables.
// RULE21 - Trap return restores and clears trap flag.
// RULE22 - Stack registers are not saved by hardware.
// RULE23 - Trap enables sit in the lower half-word.
// RULE24 - Trap enable ORs mask, returns old mask.
// RULE25 - Trap disable ANDs inverted mask, returns old.
// RULE26 - Structures chosen by priority and trap group.
`timescale 1ns/1ps
`include "ctu_cfg.svh"

module cpu_trap_unit (
  // Clock and reset.
  input wire logic sys_clk_in,
  input wire logic rst_in,
  // Pipeline state at the current instruction boundary.
  input wire logic prio_in,
  input wire logic interruptible_in,
  input wire logic [31:0] next_iptr_in,
  input wire logic [31:0] wptr_in,
  // Cause pulses from pipeline and scheduler, one per status bit 0 to 13.
  input wire logic [13:0] cause_in,
  // Trap instruction requests.
  input wire logic op_valid_in,
  input wire ctu_pkg::ctu_req_t op_in,
  output logic op_ready_out,
  output logic op_done_out,
  output logic [31:0] op_result_out,
  // Context handed back to the pipeline.
  output ctu_pkg::ctu_ctx_t ctx_out,
  // Enables and status of the current priority, for observation.
  output logic [31:0] trap_enable_mask_out,
  output logic [15:0] trap_condition_flags_out,
  // Workspace memory port.
  output ctu_pkg::ctu_mem_t mem_out,
  input wire logic [31:0] mem_rdata_in,
  input wire logic mem_ack_in
);

  // Group code of a cause bit.
  function automatic logic [1:0] group_of(input logic [3:0] bitn);
    if (bitn == `CTU_BIT_BREAK) begin
      group_of = `CTU_GRP_BREAK; // RULE1
    end else if (bitn <= `CTU_BIT_OVERFLOW) begin
      group_of = `CTU_GRP_ERRORS; // RULE2 RULE3
    end else if (bitn <= `CTU_BIT_STORE_ICPT) begin
      group_of = `CTU_GRP_SYSOPS; // RULE4 RULE5 RULE6
    end else begin
      group_of = `CTU_GRP_SCHED; // RULE7 RULE8 RULE9
    end
  endfunction : group_of

  // Lowest pending cause wins, so breakpoints beat scheduler events.
  function automatic logic [3:0] lowest(input logic [13:0] vec);
    lowest = 4'h0;
    for (int i = 13; i >= 0; i--) begin
      if (vec[i]) begin
        lowest = 4'(i);
      end
    end
  endfunction : lowest

  // Byte address of one word of a structure, per priority and group.
  function automatic logic [31:0] struct_addr(input logic [31:0] base,
      input logic prio, input logic [1:0] grp, input logic [1:0] word);
    struct_addr = base + {25'h0, prio, grp, word, 2'b00}; // RULE26
  endfunction : struct_addr

  ctu_pkg::ctu_state_t s; // Registered state.
  ctu_pkg::ctu_state_t next_s; // Next state.

  logic [13:0] pend; // Enabled conditions waiting at this priority.
  logic take; // A trap is entered in this cycle.

  // Trap instructions are refused while a sequence runs or a trap starts.
  always_comb begin
    pend = s.st[prio_in][13:0] & s.en[prio_in][13:0];
    take = (s.fsm == ctu_pkg::CTU_IDLE) && interruptible_in
      && (pend != 14'h0); // RULE16
    op_ready_out = (s.fsm == ctu_pkg::CTU_IDLE) && !take;
  end

  // Next-state logic: sequencer, instructions, then cause capture last
  // so that a cause arriving together with a clear is kept.
  always_comb begin
    logic [13:0] ev;
    logic [3:0] tb;
    logic is_load;
    logic [31:0] saddr;
    logic [31:0] aaddr;
    logic op_go;
    ev = cause_in;
    tb = lowest(pend);
    is_load = 1'b0;
    saddr = 32'h0;
    aaddr = 32'h0;
    op_go = op_valid_in && op_ready_out;
    next_s = s;
    next_s.ctx.load = 1'b0;
    next_s.op_done = 1'b0;
    next_s.prev_prio = prio_in;
    // A change of running priority is a scheduler cause.
    if (prio_in != s.prev_prio) begin
      ev[`CTU_BIT_PRIO_SWITCH] = 1'b1; // RULE8
    end
    case (s.fsm)
      ctu_pkg::CTU_IDLE: begin
        if (take) begin
          // Capture the context; next_iptr_in already names the
          // instruction after the one that trapped.
          next_s.fsm = ctu_pkg::CTU_SAVE;
          next_s.idx = 2'h0;
          next_s.tprio = prio_in;
          next_s.tgrp = group_of(tb); // RULE26
          next_s.act_bit[prio_in] = tb;
          next_s.act_grp[prio_in] = group_of(tb);
          next_s.hold_i = next_iptr_in; // RULE13
          next_s.hold_w = wptr_in;
        end else if (op_go) begin
          case (op_in.code)
            ctu_pkg::CTU_OP_TRAPENB: begin
              next_s.op_result = {16'h0, s.en[op_in.b[0]][15:0]};
              next_s.en[op_in.b[0]][15:0] =
                s.en[op_in.b[0]][15:0] | op_in.a[15:0]; // RULE23 RULE24
              next_s.op_done = 1'b1;
            end
            ctu_pkg::CTU_OP_TRAPDIS: begin
              next_s.op_result = {16'h0, s.en[op_in.b[0]][15:0]};
              next_s.en[op_in.b[0]][15:0] =
                s.en[op_in.b[0]][15:0] & ~op_in.a[15:0]; // RULE25
              next_s.op_done = 1'b1;
            end
            ctu_pkg::CTU_OP_TRET: begin
              next_s.fsm = ctu_pkg::CTU_RESTORE;
              next_s.idx = 2'h0;
              next_s.tprio = prio_in;
              next_s.tgrp = s.act_grp[prio_in];
            end
            ctu_pkg::CTU_OP_CAUSEERR: begin
              // Only enabled flags land; bit 15 marks them as software's.
              if ((op_in.a[13:0] & s.en[prio_in][13:0]) != 14'h0) begin
                ev = ev | op_in.a[13:0];
                next_s.st[prio_in][`CTU_BIT_CAUSE_ERR] = 1'b1; // RULE10
              end
              next_s.op_done = 1'b1;
            end
            default: begin
              // Structure transfers, unless the kernel intercepts them.
              is_load = (op_in.code == ctu_pkg::CTU_OP_LDTRAPH)
                || (op_in.code == ctu_pkg::CTU_OP_LDTRAPPED);
              if (is_load && s.en[prio_in][`CTU_BIT_LOAD_ICPT]) begin
                ev[`CTU_BIT_LOAD_ICPT] = 1'b1; // RULE5
                next_s.op_done = 1'b1;
              end else if (!is_load
                  && s.en[prio_in][`CTU_BIT_STORE_ICPT]) begin
                ev[`CTU_BIT_STORE_ICPT] = 1'b1; // RULE6
                next_s.op_done = 1'b1;
              end else begin
                next_s.fsm = ctu_pkg::CTU_COPY;
                next_s.idx = 2'h0;
                next_s.rd_done = 1'b0;
                next_s.cop = op_in.code;
                next_s.area = op_in.b;
                next_s.tgrp = op_in.a[1:0];
                // Handler transfers name a priority; trapped ones do not.
                next_s.tprio = ((op_in.code == ctu_pkg::CTU_OP_LDTRAPH)
                  || (op_in.code == ctu_pkg::CTU_OP_STTRAPH))
                  ? op_in.c[0] : prio_in;
              end
            end
          endcase
        end
      end
      ctu_pkg::CTU_SAVE: begin
        // Four writes; the evaluation stack stays with the handler.
        if (!s.mem.req) begin
          next_s.mem.req = 1'b1; // RULE19 RULE22
          next_s.mem.we = 1'b1;
          next_s.mem.addr = struct_addr(`CTU_TRAPPED_BASE, s.tprio,
            s.tgrp, s.idx);
          case (s.idx)
            `CTU_W_ENABLES: next_s.mem.wdata = s.en[s.tprio];
            `CTU_W_STATUS: next_s.mem.wdata = {16'h0, s.st[s.tprio]};
            `CTU_W_WPTR: next_s.mem.wdata = s.hold_w;
            default: next_s.mem.wdata = s.hold_i;
          endcase
          // Status saved above still holds the taken bit.
        end else if (mem_ack_in) begin
          next_s.mem.req = 1'b0; // RULE14
          next_s.idx = s.idx + 2'h1;
          if (s.idx == `CTU_W_IPTR) begin
            next_s.fsm = ctu_pkg::CTU_LOAD;
          end
        end
      end
      ctu_pkg::CTU_LOAD, ctu_pkg::CTU_RESTORE: begin
        // Four reads from the handler or the trapped structure.
        if (!s.mem.req) begin
          next_s.mem.req = 1'b1;
          next_s.mem.we = 1'b0;
          next_s.mem.addr = struct_addr((s.fsm == ctu_pkg::CTU_LOAD)
            ? `CTU_HANDLER_BASE : `CTU_TRAPPED_BASE,
            s.tprio, s.tgrp, s.idx); // RULE11
        end else if (mem_ack_in) begin
          next_s.mem.req = 1'b0;
          next_s.idx = s.idx + 2'h1;
          case (s.idx)
            `CTU_W_ENABLES: begin
              if (s.fsm == ctu_pkg::CTU_LOAD) begin
                next_s.en[s.tprio] = s.en[s.tprio] & mem_rdata_in; // RULE12
              end else begin
                next_s.en[s.tprio] = mem_rdata_in; // RULE21
              end
            end
            `CTU_W_STATUS: begin
              next_s.st[s.tprio] = mem_rdata_in[15:0]; // RULE20
              if (s.fsm == ctu_pkg::CTU_RESTORE) begin
                next_s.st[s.tprio][s.act_bit[s.tprio]] = 1'b0; // RULE21
                next_s.st[s.tprio][`CTU_BIT_CAUSE_ERR] = 1'b0;
              end
            end
            `CTU_W_WPTR: next_s.hold_w = mem_rdata_in;
            default: begin
              next_s.hold_i = mem_rdata_in;
              next_s.fsm = ctu_pkg::CTU_IDLE;
              next_s.ctx.load = 1'b1;
              next_s.ctx.iptr = mem_rdata_in;
              next_s.ctx.wptr = s.hold_w;
              next_s.ctx.status = s.st[s.tprio];
              next_s.op_done = (s.fsm == ctu_pkg::CTU_RESTORE);
            end
          endcase
        end
      end
      ctu_pkg::CTU_COPY: begin
        // Each word is read from the source, then written to the target.
        is_load = (s.cop == ctu_pkg::CTU_OP_LDTRAPH)
          || (s.cop == ctu_pkg::CTU_OP_LDTRAPPED);
        saddr = struct_addr(((s.cop == ctu_pkg::CTU_OP_LDTRAPH)
          || (s.cop == ctu_pkg::CTU_OP_STTRAPH))
          ? `CTU_HANDLER_BASE : `CTU_TRAPPED_BASE, s.tprio, s.tgrp, s.idx);
        aaddr = s.area + {28'h0, s.idx, 2'b00};
        if (!s.mem.req) begin
          next_s.mem.req = 1'b1;
          next_s.mem.we = s.rd_done;
          next_s.mem.addr = (is_load ^ s.rd_done) ? aaddr : saddr;
          next_s.mem.wdata = s.hold_w;
        end else if (mem_ack_in) begin
          next_s.mem.req = 1'b0;
          next_s.rd_done = !s.rd_done;
          if (!s.rd_done) begin
            next_s.hold_w = mem_rdata_in;
          end else begin
            next_s.idx = s.idx + 2'h1;
            if (s.idx == `CTU_W_IPTR) begin
              next_s.fsm = ctu_pkg::CTU_IDLE;
              next_s.op_done = 1'b1;
            end
          end
        end
      end
      default: begin
        next_s.fsm = ctu_pkg::CTU_IDLE;
      end
    endcase
    // Causes are gated by the enables of the running priority; a masked
    // cause leaves no trace. Applied last so a set beats a clear.
    next_s.st[prio_in][13:0] = next_s.st[prio_in][13:0]
      | (ev & s.en[prio_in][13:0]); // RULE15 RULE17 RULE18 RULE9
  end

  // State register with synchronous reset.
  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      s <= '0;
      s.fsm <= ctu_pkg::CTU_IDLE;
      s.en <= {2{`CTU_EN_RESET}};
      s.st <= {2{`CTU_ST_RESET}};
    end else begin
      s <= next_s;
    end
  end

  // Outputs come from the state register; the enables and flags go through a prio_in select.
  assign op_done_out = s.op_done;
  assign op_result_out = s.op_result;
  assign ctx_out = s.ctx;
  assign mem_out = s.mem;
  assign trap_enable_mask_out = s.en[prio_in];
  assign trap_condition_flags_out = s.st[prio_in];

endmodule : cpu_trap_unit

// ===== test/ctu_monitor.sv
/* Checker of the trap unit, watching only its ports.
   Assumes one clock domain and a bind to every trap unit. */
`timescale 1ns/1ps
module ctu_monitor (
  // Clock and reset.
  input wire logic sys_clk_in,
  input wire logic rst_in,
  // Pipeline side.
  input wire logic prio_in,
  input wire logic interruptible_in,
  input wire logic [13:0] cause_in,
  input wire logic op_valid_in,
  input wire ctu_pkg::ctu_req_t op_in,
  input wire logic op_ready_out,
  input wire logic op_done_out,
  input wire logic [31:0] op_result_out,
  input wire ctu_pkg::ctu_ctx_t ctx_out,
  input wire logic [31:0] trap_enable_mask_out,
  input wire logic [15:0] trap_condition_flags_out,
  // Memory side.
  input wire ctu_pkg::ctu_mem_t mem_out,
  input wire logic mem_ack_in
);
  default clocking @(posedge sys_clk_in); endclocking
  default disable iff (rst_in);
  logic [15:0] en; // Low half of the enables.
  logic [15:0] st; // Flags of the observed priority.
  logic [13:0] sets; // Cause pulses that are enabled.
  logic [13:0] drops; // Cause pulses that are masked.
  logic take; // An instruction is accepted at this edge.
  assign en = trap_enable_mask_out[15:0];
  assign st = trap_condition_flags_out;
  assign sets = cause_in & en[13:0];
  assign drops = cause_in & ~en[13:0];
  assign take = op_valid_in && op_ready_out;
  // Idle with an enabled flag pending at an interruptible point.
  sequence trap_due;
    interruptible_in && (st[13:0] & en[13:0]) != 14'h0 && !mem_out.req
    && !$past(mem_out.req) && !op_done_out && !ctx_out.load;
  endsequence
  // Enables go first, to word 0 of the trapped area (base 0x180 >> 7).
  sequence first_save;
    mem_out.req && mem_out.we && mem_out.addr[31:7] == 25'h3
    && mem_out.addr[6] == $past(prio_in) && mem_out.addr[3:2] == 2'h0
    && mem_out.wdata == $past(trap_enable_mask_out);
  endsequence
  sequence tret_take;
    take && op_in.code == ctu_pkg::CTU_OP_TRET;
  endsequence
  // A word request stands unchanged until it is acknowledged.
  chk_req_stands: assert property (mem_out.req && !mem_ack_in |=>
    mem_out.req && $stable(mem_out.addr) && $stable(mem_out.wdata))
    else $error("memory request changed before its answer");
  chk_req_gap: assert property (mem_out.req && mem_ack_in |=> !mem_out.req)
    else $error("memory request not dropped after answer");
  chk_enb_or: assert property (
    take && op_in.code == ctu_pkg::CTU_OP_TRAPENB && op_in.b[0] == prio_in
    ##1 $stable(prio_in) |-> op_done_out && op_result_out[15:0] ==
    $past(en) && en == ($past(en) | $past(op_in.a[15:0])))
    else $error("trap enable gave a wrong mask or result");
  chk_dis_and: assert property (
    take && op_in.code == ctu_pkg::CTU_OP_TRAPDIS && op_in.b[0] == prio_in
    ##1 $stable(prio_in) |-> op_done_out && op_result_out[15:0] ==
    $past(en) && en == ($past(en) & ~$past(op_in.a[15:0])))
    else $error("trap disable gave a wrong mask or result");
  chk_set_enabled: assert property (
    sets != 14'h0 && op_ready_out && !interruptible_in ##1 $stable(prio_in)
    |-> (st[13:0] & $past(sets)) == $past(sets))
    else $error("enabled cause not recorded");
  chk_ignore_masked: assert property (
    drops != 14'h0 && op_ready_out && !op_valid_in && !interruptible_in
    ##1 $stable(prio_in) |-> ((st[13:0] ^ $past(st[13:0])) & $past(drops))
    == 14'h0) else $error("masked cause changed the flags");
  // The sequencer spends one cycle in its save state before it raises the
  // first request, so the enables word shows up two edges after the take.
  chk_entry_start: assert property (trap_due ##1 !mem_out.req |=>
    first_save)
    else $error("trap entry did not save the enables first");
  chk_tret_ctx: assert property (
    tret_take |-> ##[2:100] (op_done_out && ctx_out.load))
    else $error("trap return gave no context");
  chk_load_icpt: assert property (
    take && op_in.code == ctu_pkg::CTU_OP_LDTRAPH && en[4] |=>
    op_done_out && st[4] && !mem_out.req)
    else $error("intercepted load was not refused");
endmodule : ctu_monitor
bind cpu_trap_unit ctu_monitor mon_u (.sys_clk_in, .rst_in, .prio_in,
  .interruptible_in, .cause_in, .op_valid_in, .op_in, .op_ready_out,
  .op_done_out, .op_result_out, .ctx_out, .trap_enable_mask_out,
  .trap_condition_flags_out, .mem_out, .mem_ack_in);

// ===== test/ctu_mem_model.sv
/* Workspace memory model answering the trap unit's word requests.
   Assumes requests stand until acknowledged, as the unit promises. */
`timescale 1ns/1ps
module ctu_mem_model (
  // Clock and reset.
  input wire logic sys_clk_in,
  input wire logic rst_in,
  // Request side.
  input wire ctu_pkg::ctu_mem_t mem_in,
  input wire logic [3:0] delay_in,
  // Answer side.
  output logic [31:0] rdata_out,
  output logic ack_out
);
  logic [31:0] store [logic [31:0]]; // Written words by byte address.
  logic [3:0] wait_q; // Cycles waited on the current word.
  int writes; // Words written; the stack registers never add to it.
  initial begin
    rdata_out = 32'h0;
    ack_out = 1'b0;
    writes = 0;
  end
  // Data is inverted each cycle outside the answer, so stale data never
  // passes; unwritten words read back as the inverted address.
  always @(posedge sys_clk_in) begin
    ack_out <= 1'b0;
    rdata_out <= ~rdata_out;
    if (rst_in || !mem_in.req || ack_out) begin
      wait_q <= 4'h0;
    end else if (wait_q != delay_in) begin
      wait_q <= wait_q + 4'h1;
    end else begin
      ack_out <= 1'b1;
      if (mem_in.we) begin
        store[mem_in.addr] = mem_in.wdata;
        writes = writes + 1;
      end else begin
        rdata_out <= store.exists(mem_in.addr) ?
          store[mem_in.addr] : ~mem_in.addr;
      end
    end
  end
endmodule : ctu_mem_model

// ===== test/tb.sv
/* Self-checking bench of the trap unit with a memory model.
   Assumes the checker and the memory model are compiled first. */
`timescale 1ns/1ps
`include "ctu_cfg.svh"
module tb;
  // Design inputs, changed at the falling edge.
  logic sys_clk_in, rst_in, prio_in, interruptible_in, op_valid_in;
  logic [31:0] next_iptr_in, wptr_in, mem_rdata_in;
  logic [13:0] cause_in;
  logic mem_ack_in;
  logic [3:0] delay; // Memory answer delay in cycles.
  ctu_pkg::ctu_req_t op_in;
  // Design outputs.
  logic op_ready_out, op_done_out;
  logic [31:0] op_result_out, trap_enable_mask_out;
  logic [15:0] trap_condition_flags_out;
  ctu_pkg::ctu_ctx_t ctx_out;
  ctu_pkg::ctu_mem_t mem_out;
  int fails, total_checks;
  cpu_trap_unit dut_u (.sys_clk_in, .rst_in, .prio_in, .interruptible_in,
    .next_iptr_in, .wptr_in, .cause_in, .op_valid_in, .op_in,
    .op_ready_out, .op_done_out, .op_result_out, .ctx_out,
    .trap_enable_mask_out, .trap_condition_flags_out, .mem_out,
    .mem_rdata_in, .mem_ack_in);
  ctu_mem_model mem_u (.sys_clk_in, .rst_in, .mem_in(mem_out),
    .delay_in(delay), .rdata_out(mem_rdata_in), .ack_out(mem_ack_in));
  initial begin
    sys_clk_in = 1'b0;
    forever #5 sys_clk_in = ~sys_clk_in;
  end
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      fails++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check
  task automatic report_and_stop();
    $display("checks=%0d fails=%0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : report_and_stop
  // Holds the request until accepted, then waits for completion.
  task automatic do_op(input ctu_pkg::ctu_op_t code, input logic [31:0] a,
                       input logic [31:0] b);
    int n;
    // Let an edge pass so a request never follows the last one's release
    // within one time step.
    @(negedge sys_clk_in);
    op_in = {code, a, b, 32'h0};
    op_valid_in = 1'b1;
    for (n = 0; n < 50 && op_ready_out !== 1'b1; n++) @(negedge sys_clk_in);
    @(negedge sys_clk_in);
    op_valid_in = 1'b0;
    for (n = 0; n < 200 && op_done_out !== 1'b1; n++) @(negedge sys_clk_in);
    check(op_done_out, 1'b1);
  endtask : do_op
  task automatic pulse(input logic [13:0] bits);
    cause_in = bits;
    @(negedge sys_clk_in);
    cause_in = 14'h0;
    @(negedge sys_clk_in);
  endtask : pulse
  task automatic t_masks();
    do_op(ctu_pkg::CTU_OP_TRAPENB, 32'h0000_0006, 32'h0);
    check(op_result_out, 32'h0);
    check(trap_enable_mask_out, 32'h0000_0006);
    do_op(ctu_pkg::CTU_OP_TRAPDIS, 32'h0000_0002, 32'h0);
    check(op_result_out, 32'h0000_0006);
    check(trap_enable_mask_out, 32'h0000_0004);
    pulse(14'h0002);
    check(trap_condition_flags_out, 16'h0);
    pulse(14'h0004);
    check(trap_condition_flags_out, 16'h0004);
  endtask : t_masks
  // Overflow trap of group 1 with a slow memory.
  task automatic t_entry();
    int n;
    mem_u.store[32'h110] = 32'hffff_fffb;
    mem_u.store[32'h114] = 32'h0000_0100;
    mem_u.store[32'h118] = 32'h0000_5000;
    mem_u.store[32'h11c] = 32'h0000_6000;
    repeat (3) @(negedge sys_clk_in);
    check(mem_out.req, 1'b0);
    delay = 4'h3;
    interruptible_in = 1'b1;
    for (n = 0; n < 200 && ctx_out.load !== 1'b1; n++) @(negedge sys_clk_in);
    interruptible_in = 1'b0;
    check(ctx_out.load, 1'b1);
    check(ctx_out.iptr, 32'h0000_6000);
    check(ctx_out.wptr, 32'h0000_5000);
    check(ctx_out.status, 16'h0100);
    check(trap_enable_mask_out, 32'h0);
    check(mem_u.store[32'h190], 32'h0000_0004);
    check(mem_u.store[32'h194], 32'h0000_0004);
    check(mem_u.store[32'h198], wptr_in);
    check(mem_u.store[32'h19c], next_iptr_in);
    check(mem_u.writes, 4);
    delay = 4'h0;
    do_op(ctu_pkg::CTU_OP_TRET, 32'h0, 32'h0);
    check(ctx_out.load, 1'b1);
    check(ctx_out.iptr, next_iptr_in);
    check(ctx_out.status, 16'h0);
    check(trap_enable_mask_out, 32'h0000_0004);
  endtask : t_entry
  // Intercepted transfers and an error raised by software.
  task automatic t_icpt();
    int w;
    w = mem_u.writes;
    do_op(ctu_pkg::CTU_OP_TRAPENB, 32'h0000_0030, 32'h0);
    do_op(ctu_pkg::CTU_OP_LDTRAPH, 32'h1, 32'h400);
    check(trap_condition_flags_out, 16'h0010);
    do_op(ctu_pkg::CTU_OP_STTRAPPED, 32'h1, 32'h400);
    check(trap_condition_flags_out, 16'h0030);
    check(mem_u.writes, w);
    do_op(ctu_pkg::CTU_OP_CAUSEERR, 32'h0000_0004, 32'h0);
    check(trap_condition_flags_out, 16'h8034);
  endtask : t_icpt
  // Transfers that are not intercepted: handler words out to an area, then
  // back in as the trapped words of the running priority.
  task automatic t_copy();
    int w;
    w = mem_u.writes;
    do_op(ctu_pkg::CTU_OP_TRAPDIS, 32'h0000_0030, 32'h0);
    check(op_result_out, 32'h0000_0034);
    do_op(ctu_pkg::CTU_OP_STTRAPH, 32'h1, 32'h400);
    check(mem_u.store[32'h400], 32'hffff_fffb);
    check(mem_u.store[32'h40c], 32'h0000_6000);
    do_op(ctu_pkg::CTU_OP_LDTRAPPED, 32'h1, 32'h400);
    check(mem_u.store[32'h194], 32'h0000_0100);
    check(mem_u.writes, w + 8);
    check(trap_condition_flags_out, 16'h8034);
  endtask : t_copy
  // Every cause bit, recorded at the low priority.
  task automatic t_causes();
    logic [15:0] exp;
    do_op(ctu_pkg::CTU_OP_TRAPENB, 32'h0000_3fff, 32'h1);
    check(op_result_out, 32'h0);
    prio_in = 1'b1;
    repeat (2) @(negedge sys_clk_in);
    exp = 16'h1000;
    check(trap_condition_flags_out, exp);
    for (int i = 0; i < 14; i++) begin
      exp[i] = 1'b1;
      pulse(14'h1 << i);
      check(trap_condition_flags_out, exp);
    end
  endtask : t_causes
  initial begin
    fails = 0;
    total_checks = 0;
    repeat (5000) @(posedge sys_clk_in);
    fails++;
    report_and_stop();
  end
  initial begin
    {rst_in, prio_in, interruptible_in, op_valid_in} = 4'h8;
    op_in = '0;
    cause_in = 14'h0;
    delay = 4'h0;
    next_iptr_in = 32'h0000_8004;
    wptr_in = 32'h2000_0040;
    repeat (10) @(negedge sys_clk_in);
    rst_in = 1'b0;
    check(trap_enable_mask_out, `CTU_EN_RESET);
    check(trap_condition_flags_out, `CTU_ST_RESET);
    t_masks();
    t_entry();
    t_icpt();
    t_copy();
    t_causes();
    report_and_stop();
  end
endmodule : tb
